// ==== hw/bcdr_pkg.sv ====
// Types shared by the calendar clock: bus states and the display carrier.
package bcdr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_RACK = 3'b101
    } bus_state_t;
    typedef struct packed {
        logic [3:0] display_position_four;
        logic [3:0] dig3;
        logic [3:0] dig2;
        logic [3:0] display_position_one;
        logic pm_dot;
    } bcdr_disp_t;
endpackage

// ==== hw/bcdr_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the calendar clock.
`ifndef BCDR_REGS_SVH
`define BCDR_REGS_SVH
`define BCDR_OFS_RSVD 4'h0
`define BCDR_OFS_SEC 4'h1
`define BCDR_OFS_MIN 4'h2
`define BCDR_OFS_HOUR 4'h3
`define BCDR_OFS_WDAY 4'h4
`define BCDR_OFS_DATE 4'h5
`define BCDR_OFS_CMON 4'h6
`define BCDR_OFS_YEAR 4'h7
`define BCDR_OFS_TRIM 4'h8
`define BCDR_OFS_WDOG 4'h9
`define BCDR_OFS_AMON 4'ha
`define BCDR_OFS_ADATE 4'hb
`define BCDR_OFS_AHOUR 4'hc
`define BCDR_OFS_AMIN 4'hd
`define BCDR_OFS_ASEC 4'he
`define BCDR_OFS_FLAGS 4'hf
`define BCDR_BIT_HALT 7
`define BCDR_BIT_FMT12 7
`define BCDR_BIT_TRIM_SIGN 5
`define BCDR_BIT_AFE 7
`define BCDR_BIT_ABE 5
`define BCDR_BIT_WDFE 7
`define BCDR_BIT_RPT_A 7
`define BCDR_BIT_RPT_B 6
`define BCDR_RST_BYTE 8'h00
// Repeat codes written as {rpt6, rpt5, rpt4, rpt3, rpt2, rpt1}.
`define BCDR_RPT_SEC 6'h1f
`define BCDR_RPT_MIN 6'h1e
`define BCDR_RPT_HOUR 6'h1c
`define BCDR_RPT_DAY 6'h18
`define BCDR_RPT_WEEK 6'h38
`define BCDR_RPT_MONTH 6'h10
`define BCDR_RPT_YEAR 6'h00
// Time base: crystal edges per second and sub-second tick masks.
`define BCDR_XT_HZ 32768
`define BCDR_MASK_SIXTEENTH 16'h07ff
`define BCDR_MASK_QUARTER 16'h1fff
// Bus address of the slave; the value is arbitrary.
`define BCDR_SLAVE_ADDR 7'h2a
`endif

// ==== hw/bcdr_rtc.sv ====
// BCD calendar clock with alarm, watchdog, display selection and two-wire register access.
`timescale 1ns/1ps
`default_nettype none
`include "bcdr_regs.svh"
module bcdr_rtc #(
    parameter int XT_HZ = `BCDR_XT_HZ,
    parameter logic [6:0] SLAVE_ADDR = `BCDR_SLAVE_ADDR
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Two-wire bus, open drain data
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Time base and system state
    input wire logic XT32K,
    input wire logic STANDBY,
    input wire logic ON_BATTERY,
    input wire logic IRQ_ACK,
    // Events
    output logic ALARM_IRQ,
    output logic WDOG_IRQ,
    output logic WAKE_REQ,
    // Display
    output var bcdr_pkg::bcdr_disp_t DISP
);
    logic [7:0] mem_r [0:15];
    logic [7:0] stage_r [0:15];
    logic [15:0] dirty_r;
    logic [3:0] ptr_r;

    // ****************************************
    // Synchronisers and time base
    // ****************************************
    logic xt_m_r, xt_s_r, xt_p_r;
    logic scl_m_r, scl_s_r, scl_p_r;
    logic sda_m_r, sda_s_r, sda_p_r;
    logic [15:0] div_r;
    logic sec_tick;
    logic xt_edge;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            {xt_m_r, xt_s_r, xt_p_r} <= 3'h0;
            {scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
        end else begin
            {xt_m_r, xt_s_r, xt_p_r} <= {XT32K, xt_m_r, xt_s_r};
            {scl_m_r, scl_s_r, scl_p_r} <= {SCL_IN, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_p_r} <= {SDA_IN, sda_m_r, sda_s_r};
        end
    end

    assign xt_edge = xt_s_r & ~xt_p_r;
    assign sec_tick = xt_edge && (div_r == 16'(XT_HZ - 1));

    // The sub-second ticks assume a power-of-two crystal rate.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_r <= 16'h0000;
        end else if (sec_tick) begin
            div_r <= 16'h0000;
        end else if (xt_edge) begin
            div_r <= div_r + 16'h0001;
        end
    end

    // ****************************************
    // Two-wire bus slave
    // ****************************************
    bcdr_pkg::bus_state_t state_r;
    logic [7:0] sh_r, out_r;
    logic [3:0] cnt_r;
    logic rw_r, first_r, nack_r, oe_r;
    logic start_det, stop_det, scl_rise, scl_fall, wr_byte, commit_now;

    assign start_det = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
    assign stop_det = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
    assign scl_rise = scl_s_r & ~scl_p_r;
    assign scl_fall = ~scl_s_r & scl_p_r;
    assign wr_byte = scl_fall & ~start_det & ~stop_det & (state_r == bcdr_pkg::ST_WRITE)
                     & (cnt_r == 4'h8) & ~first_r;
    assign commit_now = stop_det & (dirty_r != 16'h0000);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_r <= bcdr_pkg::ST_IDLE;
            sh_r <= 8'h00;
            out_r <= 8'h00;
            cnt_r <= 4'h0;
            ptr_r <= 4'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            oe_r <= 1'b0;
            dirty_r <= 16'h0000;
        end else if (start_det) begin
            // A new start drops whatever an unfinished write had staged.
            state_r <= bcdr_pkg::ST_ADDR;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
            dirty_r <= 16'h0000;
        end else if (stop_det) begin
            state_r <= bcdr_pkg::ST_IDLE;
            oe_r <= 1'b0;
            dirty_r <= 16'h0000;
        end else if (scl_rise) begin
            if (state_r == bcdr_pkg::ST_ADDR || state_r == bcdr_pkg::ST_WRITE) begin
                sh_r <= {sh_r[6:0], sda_s_r};
                cnt_r <= cnt_r + 4'h1;
            end
            if (state_r == bcdr_pkg::ST_RACK) begin
                nack_r <= sda_s_r;
            end
        end else if (scl_fall) begin
            unique case (state_r)
                bcdr_pkg::ST_IDLE: begin
                    oe_r <= 1'b0;
                end
                bcdr_pkg::ST_ADDR: begin
                    if (cnt_r == 4'h8) begin
                        if (sh_r[7:1] == SLAVE_ADDR) begin
                            oe_r <= 1'b1;
                            rw_r <= sh_r[0];
                            first_r <= ~sh_r[0];
                            state_r <= bcdr_pkg::ST_ACK;
                        end else begin
                            state_r <= bcdr_pkg::ST_IDLE;
                        end
                    end
                end
                bcdr_pkg::ST_WRITE: begin
                    if (cnt_r == 4'h8) begin
                        oe_r <= 1'b1;
                        state_r <= bcdr_pkg::ST_ACK;
                        first_r <= 1'b0;
                        if (first_r) begin
                            ptr_r <= sh_r[3:0];
                        end else begin
                            ptr_r <= ptr_r + 4'h1;
                            dirty_r[ptr_r] <= 1'b1;
                        end
                    end
                end
                bcdr_pkg::ST_ACK: begin
                    cnt_r <= 4'h0;
                    if (rw_r) begin
                        out_r <= mem_r[ptr_r];
                        oe_r <= ~mem_r[ptr_r][7];
                        ptr_r <= ptr_r + 4'h1;
                        cnt_r <= 4'h1;
                        state_r <= bcdr_pkg::ST_READ;
                    end else begin
                        oe_r <= 1'b0;
                        state_r <= bcdr_pkg::ST_WRITE;
                    end
                end
                bcdr_pkg::ST_READ: begin
                    if (cnt_r == 4'h8) begin
                        oe_r <= 1'b0;
                        state_r <= bcdr_pkg::ST_RACK;
                    end else begin
                        oe_r <= ~out_r[6];
                        out_r <= {out_r[6:0], 1'b0};
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                bcdr_pkg::ST_RACK: begin
                    if (nack_r) begin
                        state_r <= bcdr_pkg::ST_IDLE;
                    end else begin
                        out_r <= mem_r[ptr_r];
                        oe_r <= ~mem_r[ptr_r][7];
                        ptr_r <= ptr_r + 4'h1;
                        cnt_r <= 4'h1;
                        state_r <= bcdr_pkg::ST_READ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (wr_byte) begin
            stage_r[ptr_r] <= sh_r;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            SDA_OE <= oe_r;
        end
    end

    // ****************************************
    // Calendar arithmetic
    // ****************************************
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
        if (v == last) begin
            bcd_step = first;
        end else if (v[3:0] == 4'h9) begin
            bcd_step = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_step = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic is_leap(input logic [7:0] y, input logic [1:0] cb);
        logic by4;
        by4 = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                   : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        is_leap = (y == 8'h00) ? (cb == 2'b00) : by4;
    endfunction

    logic [7:0] sec, min, hr, dat, mon, yr, last_day;
    logic [7:0] nsec, nmin, nhr, ndat, nmon, nyr;
    logic [2:0] wday, nwday;
    logic [1:0] cb, ncb;
    logic c_s, c_m, c_h, c_d, c_mo, c_y, halt;

    always_comb begin
        sec = {1'b0, mem_r[`BCDR_OFS_SEC][6:0]};
        min = {1'b0, mem_r[`BCDR_OFS_MIN][6:0]};
        hr = {2'b00, mem_r[`BCDR_OFS_HOUR][5:0]};
        dat = {2'b00, mem_r[`BCDR_OFS_DATE][5:0]};
        mon = {3'b000, mem_r[`BCDR_OFS_CMON][4:0]};
        yr = mem_r[`BCDR_OFS_YEAR];
        wday = mem_r[`BCDR_OFS_WDAY][2:0];
        cb = mem_r[`BCDR_OFS_CMON][7:6];
        halt = mem_r[`BCDR_OFS_SEC][`BCDR_BIT_HALT];
        unique case (mon)
            8'h02: last_day = is_leap(yr, cb) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
        c_s = (sec == 8'h59);
        c_m = c_s && (min == 8'h59);
        c_h = c_m && (hr == 8'h23);
        c_d = c_h && (dat == last_day);
        c_mo = c_d && (mon == 8'h12);
        c_y = c_mo && (yr == 8'h99);
        nsec = bcd_step(sec, 8'h59, 8'h00);
        nmin = c_s ? bcd_step(min, 8'h59, 8'h00) : min;
        nhr = c_m ? bcd_step(hr, 8'h23, 8'h00) : hr;
        nwday = c_h ? ((wday == 3'h7) ? 3'h1 : wday + 3'h1) : wday;
        ndat = c_h ? bcd_step(dat, last_day, 8'h01) : dat;
        nmon = c_d ? bcd_step(mon, 8'h12, 8'h01) : mon;
        nyr = c_mo ? bcd_step(yr, 8'h99, 8'h00) : yr;
        ncb = c_y ? cb + 2'b01 : cb;
    end

    // ****************************************
    // Register file
    // ****************************************
    // A host write lands after the tick so that freshly set time is not advanced twice.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= `BCDR_RST_BYTE;
            end
        end else begin
            if (sec_tick && !halt) begin
                mem_r[`BCDR_OFS_SEC][6:0] <= nsec[6:0];
                mem_r[`BCDR_OFS_MIN][6:0] <= nmin[6:0];
                mem_r[`BCDR_OFS_HOUR][5:0] <= nhr[5:0];
                mem_r[`BCDR_OFS_WDAY][2:0] <= nwday;
                mem_r[`BCDR_OFS_DATE][5:0] <= ndat[5:0];
                mem_r[`BCDR_OFS_CMON] <= {ncb, mem_r[`BCDR_OFS_CMON][5], nmon[4:0]};
                mem_r[`BCDR_OFS_YEAR] <= nyr;
            end
            for (int i = 1; i < 16; i++) begin
                if (commit_now && dirty_r[i]) begin
                    mem_r[i] <= stage_r[i];
                end
            end
        end
    end

    // ****************************************
    // Alarm
    // ****************************************
    logic [5:0] rpt;
    logic m_s, m_mi, m_h, m_d, m_mo, m_w, match, abe, afe, alarm_hit;
    logic tick_d_r, alarm_flag_r;

    always_comb begin
        rpt = {mem_r[`BCDR_OFS_AHOUR][`BCDR_BIT_RPT_B], mem_r[`BCDR_OFS_ADATE][`BCDR_BIT_RPT_B],
               mem_r[`BCDR_OFS_ADATE][`BCDR_BIT_RPT_A], mem_r[`BCDR_OFS_AHOUR][`BCDR_BIT_RPT_A],
               mem_r[`BCDR_OFS_AMIN][`BCDR_BIT_RPT_A], mem_r[`BCDR_OFS_ASEC][`BCDR_BIT_RPT_A]};
        m_s = sec[6:0] == mem_r[`BCDR_OFS_ASEC][6:0];
        m_mi = min[6:0] == mem_r[`BCDR_OFS_AMIN][6:0];
        m_h = hr[5:0] == mem_r[`BCDR_OFS_AHOUR][5:0];
        m_d = dat[5:0] == mem_r[`BCDR_OFS_ADATE][5:0];
        m_mo = mon[4:0] == mem_r[`BCDR_OFS_AMON][4:0];
        m_w = wday == mem_r[`BCDR_OFS_FLAGS][6:4];
        case (rpt)
            `BCDR_RPT_SEC: match = 1'b1;
            `BCDR_RPT_MIN: match = m_s;
            `BCDR_RPT_HOUR: match = m_s & m_mi;
            `BCDR_RPT_DAY: match = m_s & m_mi & m_h;
            `BCDR_RPT_WEEK: match = m_s & m_mi & m_h & m_w;
            `BCDR_RPT_MONTH: match = m_s & m_mi & m_h & m_d;
            `BCDR_RPT_YEAR: match = m_s & m_mi & m_h & m_d & m_mo;
            default: match = 1'b1;
        endcase
        abe = mem_r[`BCDR_OFS_AMON][`BCDR_BIT_ABE];
        afe = mem_r[`BCDR_OFS_AMON][`BCDR_BIT_AFE];
        alarm_hit = tick_d_r & match & (~ON_BATTERY | abe);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            tick_d_r <= 1'b0;
            alarm_flag_r <= 1'b0;
            ALARM_IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
        end else begin
            tick_d_r <= sec_tick & ~halt;
            if (alarm_hit) begin
                alarm_flag_r <= 1'b1;
            end else if (IRQ_ACK) begin
                alarm_flag_r <= 1'b0;
            end
            ALARM_IRQ <= alarm_flag_r & afe;
            WAKE_REQ <= alarm_hit & STANDBY;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    logic [2:0] wd_res;
    logic [4:0] wd_cnt_r;
    logic [1:0] wd_sub_r;
    logic wd_tick, wd_flag_r;

    always_comb begin
        wd_res = {mem_r[`BCDR_OFS_WDOG][7], mem_r[`BCDR_OFS_WDOG][1:0]};
        unique case (wd_res)
            3'h0: wd_tick = xt_edge && ((div_r & `BCDR_MASK_SIXTEENTH) == `BCDR_MASK_SIXTEENTH);
            3'h1: wd_tick = xt_edge && ((div_r & `BCDR_MASK_QUARTER) == `BCDR_MASK_QUARTER);
            3'h3: wd_tick = sec_tick && (wd_sub_r == 2'h3);
            default: wd_tick = sec_tick;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wd_cnt_r <= 5'h00;
            wd_sub_r <= 2'h0;
            wd_flag_r <= 1'b0;
            WDOG_IRQ <= 1'b0;
        end else begin
            if (sec_tick) begin
                wd_sub_r <= wd_sub_r + 2'h1;
            end
            if (commit_now && dirty_r[`BCDR_OFS_WDOG]) begin
                wd_cnt_r <= stage_r[`BCDR_OFS_WDOG][6:2];
            end else if (wd_tick && wd_cnt_r != 5'h00) begin
                wd_cnt_r <= wd_cnt_r - 5'h01;
            end
            if (wd_tick && wd_cnt_r == 5'h01 && mem_r[`BCDR_OFS_FLAGS][`BCDR_BIT_WDFE]) begin
                wd_flag_r <= 1'b1;
            end else if (IRQ_ACK) begin
                wd_flag_r <= 1'b0;
            end
            WDOG_IRQ <= wd_flag_r;
        end
    end

    // ****************************************
    // Display selection
    // ****************************************
    logic [4:0] hbin, h12;
    logic [7:0] hshow, pair_hi, pair_lo;
    logic fmt12, pm;

    always_comb begin
        fmt12 = mem_r[`BCDR_OFS_TRIM][`BCDR_BIT_FMT12];
        hbin = 5'({hr[5:4], 3'b000}) + 5'({hr[5:4], 1'b0}) + 5'(hr[3:0]);
        pm = hbin >= 5'd12;
        if (hbin == 5'd0) begin
            h12 = 5'd12;
        end else if (hbin > 5'd12) begin
            h12 = hbin - 5'd12;
        end else begin
            h12 = hbin;
        end
        hshow = (h12 >= 5'd10) ? {4'h1, 4'(h12 - 5'd10)} : {4'h0, h12[3:0]};
        if (!fmt12) begin
            hshow = hr;
        end
        unique case (mem_r[`BCDR_OFS_HOUR][7:6])
            2'b00: {pair_hi, pair_lo} = {hshow, min};
            2'b01: {pair_hi, pair_lo} = {min, sec};
            2'b10: {pair_hi, pair_lo} = {dat, mon};
            2'b11: {pair_hi, pair_lo} = {mon, dat};
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            DISP <= '0;
        end else begin
            DISP.display_position_one <= pair_hi[7:4];
            DISP.dig2 <= pair_hi[3:0];
            DISP.dig3 <= pair_lo[7:4];
            DISP.display_position_four <= pair_lo[3:0];
            DISP.pm_dot <= fmt12 & pm & (mem_r[`BCDR_OFS_HOUR][7:6] == 2'b00);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_sec_wrap;
        @(posedge MCLK) disable iff (RST)
        sec_tick && !halt && !commit_now && c_h |=> sec == 8'h00 && min == 8'h00 && hr == 8'h00;
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not carry into minutes");

    property p_century;
        @(posedge MCLK) disable iff (RST)
        sec_tick && !halt && !commit_now && c_y |=> yr == 8'h00 && cb == $past(cb) + 2'b01;
    endproperty
    a_century: assert property (p_century) else $error("century bits did not advance");

    property p_feb_common;
        @(posedge MCLK) disable iff (RST)
        sec_tick && !halt && !commit_now && c_h && mon == 8'h02 && dat == 8'h28
        && (yr == 8'h01 || (yr == 8'h00 && cb != 2'b00))
        |=> dat == 8'h01 && mon == 8'h03;
    endproperty
    a_feb_common: assert property (p_feb_common) else $error("common year february did not end at 28");

    property p_feb_leap;
        @(posedge MCLK) disable iff (RST)
        sec_tick && !halt && !commit_now && c_h && mon == 8'h02 && dat == 8'h28 && yr == 8'h00 && cb == 2'b00
        |=> dat == 8'h29;
    endproperty
    a_feb_leap: assert property (p_feb_leap) else $error("leap year february ended at 28");

    property p_bad_code;
        @(posedge MCLK) disable iff (RST)
        tick_d_r && rpt == 6'h01 && (!ON_BATTERY || abe) |=> alarm_flag_r;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("undefined repeat code did not fire");

    property p_irq_gate;
        @(posedge MCLK) disable iff (RST)
        ALARM_IRQ |-> $past(afe) && $past(alarm_flag_r);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("alarm interrupt without flag and enable");

    property p_irq_ack;
        @(posedge MCLK) disable iff (RST)
        IRQ_ACK && !alarm_hit ##1 !alarm_hit |=> !ALARM_IRQ;
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("alarm interrupt survived acknowledge");

    property p_wd_gate;
        @(posedge MCLK) disable iff (RST)
        $rose(wd_flag_r) |-> $past(mem_r[`BCDR_OFS_FLAGS][`BCDR_BIT_WDFE]);
    endproperty
    a_wd_gate: assert property (p_wd_gate) else $error("watchdog flag set while disabled");

    property p_ptr_step;
        @(posedge MCLK) disable iff (RST)
        wr_byte |=> ptr_r == $past(ptr_r) + 4'h1 && dirty_r[$past(ptr_r)];
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step after a data byte");

    c_alarm_fire: cover property (@(posedge MCLK) disable iff (RST) $rose(ALARM_IRQ));
    c_year_wrap: cover property (@(posedge MCLK) disable iff (RST) sec_tick && !halt && c_y);
    c_read_byte: cover property (@(posedge MCLK) disable iff (RST) state_r == bcdr_pkg::ST_RACK);
    c_commit: cover property (@(posedge MCLK) disable iff (RST) commit_now);
endmodule // bcdr_rtc
`default_nettype wire

// ==== tb/bcdr_host_model.sv ====
// Two-wire host model that runs bus transfers for the calendar clock bench.
`timescale 1ns/1ps
`default_nettype none
module bcdr_host_model (
    // Clock and resolved data line
    input wire logic clk,
    input wire logic sda_in,
    // Bus drive, open drain data
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data moves only while the clock line is low, so no false start or stop is seen.
    task automatic bitx(input logic d, output logic s);
        hc(3);
        sda_oe <= !d;
        hc(10);
        scl <= 1'b1;
        hc(6);
        s = sda_in;
        hc(6);
        scl <= 1'b0;
    endtask
    // Start is cond(0, 1) and stop is cond(1, 0); a data write ends in a stop, a pointer set before a read in a repeated start.
    task automatic cond(input logic a, input logic z);
        hc(3);
        sda_oe <= a;
        hc(10);
        scl <= 1'b1;
        hc(10);
        sda_oe <= z;
        hc(10);
        scl <= !z;
        hc(10);
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            bitx(i > 0 ? d[i - 1] : last, q[i]);
        end
    endtask
endmodule // bcdr_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the calendar clock: rollover, display pair, alarm and its acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "bcdr_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("mismatch %0t got %h", $time, a); end end
module testbench;
    logic mclk = 0, rst = 1, xt = 0, stby = 0, ack = 0, wake_seen = 0, batt = 0;
    logic scl, h_oe, d_oe, sda_o, alarm_irq, wdog_irq, wake;
    logic [7:0] b [8];
    logic [7:0] roll [8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h01, 8'h41, 8'h00};
    logic [8:0] r;
    wire logic sda = !h_oe && (!d_oe || sda_o);
    bcdr_pkg::bcdr_disp_t disp;
    int mismatches = 0, num_checks = 0, cyc = 0;
    bcdr_rtc #(.XT_HZ(512)) DUT (.MCLK(mclk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(d_oe),
        .XT32K(xt), .STANDBY(stby), .ON_BATTERY(batt), .IRQ_ACK(ack), .ALARM_IRQ(alarm_irq), .WDOG_IRQ(wdog_irq),
        .WAKE_REQ(wake), .DISP(disp));
    bcdr_host_model HOST (.clk(mclk), .sda_in(sda), .scl(scl), .sda_oe(h_oe));
    always #4 mclk = !mclk;
    always #80 xt = !xt;
    always @(posedge mclk) begin
        wake_seen <= wake_seen || wake;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Both interrupts must be low three edges after the acknowledge is taken.
    task automatic ack_irq();
        ack <= 1'b1;
        @(posedge mclk);
        ack <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(alarm_irq, 1'b0)
        `CHK(wdog_irq, 1'b0)
    endtask
    task automatic open_ptr(input logic [3:0] p);
        HOST.cond(1'b0, 1'b1);
        HOST.xfer({`BCDR_SLAVE_ADDR, 1'b0}, 1'b1, r);
        `CHK(r[0], 1'b0)
        HOST.xfer({4'h0, p}, 1'b1, r);
    endtask
    task automatic wr(input logic [3:0] p, input int n);
        open_ptr(p);
        for (int i = 0; i < n; i++)
            HOST.xfer(b[i], 1'b1, r);
        HOST.cond(1'b1, 1'b0);
    endtask
    task automatic rd(input logic [3:0] p, input int n);
        open_ptr(p);
        HOST.cond(1'b0, 1'b1);
        HOST.xfer({`BCDR_SLAVE_ADDR, 1'b1}, 1'b1, r);
        for (int i = 0; i < n; i++) begin
            HOST.xfer(8'hff, i == n - 1, r);
            b[i] = r[8:1];
        end
        HOST.cond(1'b1, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(`BCDR_OFS_AMON, 1);
        `CHK(b[0], 8'h00)
        // Last second of a century, minute-second view, weekday at its top value.
        b = '{8'h59, 8'h59, 8'h63, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00};
        wr(`BCDR_OFS_SEC, 7);
        `CHK(disp, 17'h12b2a)
        for (int i = 0; i < 12000 && disp.display_position_four === 4'h9; i++)
            @(posedge mclk);
        rd(`BCDR_OFS_RSVD, 8);
        foreach (b[i]) `CHK(b[i], roll[i])
        stby <= 1'b1;
        b = '{8'h80, 8'hc0, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
        wr(`BCDR_OFS_AMON, 5);
        for (int i = 0; i < 12000 && alarm_irq !== 1'b1; i++)
            @(posedge mclk);
        repeat (2) @(posedge mclk);
        `CHK(alarm_irq, 1'b1)
        `CHK(wake_seen, 1'b1)
        ack_irq();
        // One-second watchdog, undefined repeat code, then a leap February in century 00.
        b = '{8'h06, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
        wr(`BCDR_OFS_WDOG, 7);
        b = '{8'h59, 8'h59, 8'ha3, 8'h01, 8'h28, 8'h02, 8'h00, 8'h00};
        wr(`BCDR_OFS_SEC, 7);
        for (int i = 0; i < 12000 && disp.dig2 === 4'h8; i++)
            @(posedge mclk);
        repeat (3) @(posedge mclk);
        `CHK(disp, 17'h04124)
        `CHK(alarm_irq, 1'b1)
        `CHK(wdog_irq, 1'b1)
        ack_irq();
        // On backup power with the backup alarm off; 12-hour view, century 01 year 00.
        batt <= 1'b1;
        b = '{8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h42, 8'h00, 8'h80};
        wr(`BCDR_OFS_SEC, 8);
        `CHK(disp, 17'h12a23)
        for (int i = 0; i < 12000 && disp.display_position_four === 4'h9; i++)
            @(posedge mclk);
        repeat (3) @(posedge mclk);
        `CHK(disp, 17'h00042)
        `CHK(alarm_irq, 1'b0)
        `CHK(wdog_irq, 1'b0)
        rd(`BCDR_OFS_DATE, 2);
        `CHK(b[0], 8'h01)
        `CHK(b[1], 8'h43)
        close_out();
    end
endmodule // testbench
`default_nettype wire
